// ### src/smcr_report.sv
// Select-with-message command tracker and completion reporter
//
// How it works
// - Bus reset while waiting for bus free reports code 01, step 00.
// - Bus reset during arbitration reports code 01, step 01.
// - Bus reset during selection reports code 01, step 02.
// - Bus reset during message out ends at once, code 01 step 03.
// - Bus reset after message out finished reports code 01, step 04.
// - Handshake timeout during message out reports code 2C, step 03.
// - Unexpected bus free during message out reports code 31, step 03.
// - Target phase change during message out reports code 32, step 03.
// - First request not message out: code 54 step 03, ATN held.
// - Wrong first phase, one message taken, ATN off: code 55 step 03.
// - Wrong first phase, one status taken, ATN off: code 56 step 03.
// - Normal end code 60; step 04 with ACK held, 0C if released.
// - Lost arbitration then reselected: 64/00, then reselection result.
// - Already reselected at issue: reselection result first, then 64.
// - Mid-transfer conditions end the command at once; bus goes quiet.
// - Single message or status reports need automatic receive mode.
// - Manual ACK mode leaves the final ACK asserted.
// - Automatic ACK mode releases the final ACK itself.
//
// Implementation choices: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none

module smcr_report (
	input  wire logic                     MCLK,
	input  wire logic                     RESET,
	input  wire logic                     PSEL,
	input  wire logic                     PENABLE,
	input  wire logic                     PWRITE,
	input  wire logic [11:0]              PADDR,
	input  wire logic [31:0]              PWDATA,
	output var  logic [31:0]              PRDATA,
	output var  logic                     PREADY,
	output var  logic                     PSLVERR,
	input  wire smcr_pkg::smcr_evt_t      EVT,
	input  wire logic                     RESEL_ACTIVE,
	input  wire smcr_pkg::smcr_rep_t      RESEL_RESULT,
	output var  logic                     CMD_START,
	output var  logic                     CMD_ABORT,
	output var  logic                     ATN,
	output var  logic                     FINAL_ACK_RELEASE,
	output var  logic                     IRQ
);
	import smcr_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	smcr_regs_t r;
	smcr_regs_t next_r;

	localparam smcr_regs_t REGS_RESET = '{
		st:       S_IDLE,
		got_req:  1'b0,
		auto_rx:  1'b0,
		auto_ack: 1'b0,
		int_en:   '0,
		int_st:   '0,
		cur:      '0,
		pend_v:   1'b0,
		pend:     '0,
		atn:      1'b0,
		start:    1'b0,
		abort:    1'b0,
		ack_rel:  1'b0,
		irq:      1'b0,
		pready:   1'b0,
		pslverr:  1'b0,
		prdata:   '0
	};

	// ----------------------------------------------------------------
	// Report posting
	// ----------------------------------------------------------------
	// Shown slot first, one pending slot behind it, overflow flagged
	function automatic smcr_regs_t post(input smcr_regs_t s,
	                                    input logic [7:0] code,
	                                    input logic [7:0] step);
		smcr_regs_t o;
		o = s;
		if (!o.int_st[INT_REPORT]) begin
			o.cur.code = code;
			o.cur.step = step;
			o.int_st[INT_REPORT] = 1'b1;
		end else if (!o.pend_v) begin
			o.pend.code = code;
			o.pend.step = step;
			o.pend_v = 1'b1;
		end else begin
			o.int_st[INT_OVERFLOW] = 1'b1;
		end
		return o;
	endfunction

	// Ends the command: back to idle, ATN released
	function automatic smcr_regs_t finish(input smcr_regs_t s,
	                                      input logic [7:0] code,
	                                      input logic [7:0] step);
		smcr_regs_t o;
		o = post(s, code, step);
		o.st = S_IDLE;
		o.atn = 1'b0;
		return o;
	endfunction

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	logic setup;
	logic access;
	logic wr;
	logic start_req;

	always_comb begin
		next_r = r;
		setup = PSEL && !PENABLE;
		access = PSEL && PENABLE && r.pready;
		wr = access && PWRITE && !r.pslverr;
		start_req = 1'b0;
		next_r.start = 1'b0;
		next_r.abort = 1'b0;
		next_r.ack_rel = 1'b0;

		// Bus slave: answer prepared in the setup cycle
		next_r.pready = setup;
		if (setup) begin
			next_r.pslverr = 1'b0;
			next_r.prdata = '0;
			unique case (PADDR)
				ADDR_CTRL: begin
					next_r.prdata[CTRL_AUTO_RX] = r.auto_rx;
					next_r.prdata[CTRL_AUTO_ACK] = r.auto_ack;
				end
				ADDR_REPORT: begin
					next_r.prdata[REP_CODE_LSB +: 8] = r.cur.code;
					next_r.prdata[REP_STEP_LSB +: 8] = r.cur.step;
					next_r.prdata[REP_PEND] = r.pend_v;
					next_r.prdata[REP_BUSY] = (r.st != S_IDLE);
				end
				ADDR_INT_STAT: begin
					next_r.prdata[INT_W-1:0] = r.int_st;
				end
				ADDR_INT_CLR: begin
					next_r.prdata = '0;
				end
				ADDR_INT_EN: begin
					next_r.prdata[INT_W-1:0] = r.int_en;
				end
				default: begin
					next_r.pslverr = 1'b1;
				end
			endcase
		end else if (access) begin
			next_r.pslverr = 1'b0;
		end

		// Register writes
		if (wr) begin
			unique case (PADDR)
				ADDR_CTRL: begin
					next_r.auto_rx = PWDATA[CTRL_AUTO_RX];
					next_r.auto_ack = PWDATA[CTRL_AUTO_ACK];
					start_req = PWDATA[CTRL_START];
				end
				ADDR_INT_CLR: begin
					// Acknowledge moves the pending report forward
					if (PWDATA[INT_REPORT] && r.int_st[INT_REPORT]) begin
						if (r.pend_v) begin
							next_r.cur = r.pend;
							next_r.pend_v = 1'b0;
						end else begin
							next_r.int_st[INT_REPORT] = 1'b0;
						end
					end
					if (PWDATA[INT_OVERFLOW]) begin
						next_r.int_st[INT_OVERFLOW] = 1'b0;
					end
				end
				ADDR_INT_EN: begin
					next_r.int_en = PWDATA[INT_W-1:0];
				end
				default: begin
				end
			endcase
		end

		// Command sequence; posts follow the clear so a set wins
		unique case (r.st)
			S_IDLE: begin
				if (start_req) begin
					next_r.start = 1'b1;
					next_r.atn = 1'b1;
					next_r.got_req = 1'b0;
					if (RESEL_ACTIVE) begin
						next_r.st = S_PRE_RESEL;
					end else begin
						next_r.st = S_WAIT_FREE;
					end
				end
			end
			S_PRE_RESEL: begin
				if (EVT.resel_op_done) begin
					next_r = post(next_r, RESEL_RESULT.code,
					              RESEL_RESULT.step);
					next_r = finish(next_r, CODE_RESEL, STEP_WAIT);
				end
			end
			S_WAIT_FREE: begin
				if (EVT.bus_reset) begin
					next_r = finish(next_r, CODE_RESET, STEP_WAIT);
				end else if (EVT.bus_free) begin
					next_r.st = S_ARB;
				end
			end
			S_ARB: begin
				if (EVT.bus_reset) begin
					next_r = finish(next_r, CODE_RESET, STEP_ARB);
				end else if (EVT.arb_won) begin
					next_r.st = S_SEL;
				end else if (EVT.arb_lost) begin
					next_r.st = S_RESEL_W;
				end
			end
			S_RESEL_W: begin
				if (EVT.bus_reset) begin
					next_r = finish(next_r, CODE_RESET, STEP_ARB);
				end else if (EVT.reselected) begin
					next_r = post(next_r, CODE_RESEL, STEP_WAIT);
					next_r.atn = 1'b0;
					next_r.st = S_RESEL_OP;
				end
			end
			S_RESEL_OP: begin
				if (EVT.resel_op_done) begin
					next_r = finish(next_r, RESEL_RESULT.code,
					                RESEL_RESULT.step);
				end
			end
			S_SEL: begin
				if (EVT.bus_reset) begin
					next_r = finish(next_r, CODE_RESET, STEP_SEL);
				end else if (EVT.sel_done) begin
					next_r.st = S_MSG;
				end
			end
			S_MSG: begin
				if (EVT.bus_reset) begin
					next_r = finish(next_r, CODE_RESET, STEP_MSG);
					next_r.abort = 1'b1;
				end else if (EVT.reqack_timeout) begin
					next_r = finish(next_r, CODE_TIMEOUT, STEP_MSG);
					next_r.abort = 1'b1;
				end else if (EVT.bus_free) begin
					next_r = finish(next_r, CODE_FREE, STEP_MSG);
					next_r.abort = 1'b1;
				end else if (EVT.first_req && !r.got_req) begin
					next_r.got_req = 1'b1;
					if (!EVT.first_req_msgout) begin
						if (r.auto_rx) begin
							next_r.atn = 1'b0;
							next_r.st = S_RECV;
						end else begin
							next_r = post(next_r, CODE_NOT_MO, STEP_MSG);
							next_r.st = S_IDLE;
						end
					end
				end else if (EVT.phase_change) begin
					next_r = finish(next_r, CODE_PHASE, STEP_MSG);
					next_r.abort = 1'b1;
				end else if (EVT.msg_done) begin
					next_r.atn = 1'b0;
					next_r.st = S_FIN;
				end
			end
			S_RECV: begin
				if (EVT.bus_reset) begin
					next_r = finish(next_r, CODE_RESET, STEP_MSG);
					next_r.abort = 1'b1;
				end else if (EVT.reqack_timeout) begin
					next_r = finish(next_r, CODE_TIMEOUT, STEP_MSG);
					next_r.abort = 1'b1;
				end else if (EVT.in_msg_done) begin
					next_r = finish(next_r, CODE_RX_MSG, STEP_MSG);
				end else if (EVT.in_status_done) begin
					next_r = finish(next_r, CODE_RX_STAT, STEP_MSG);
				end
			end
			S_FIN: begin
				if (EVT.bus_reset) begin
					next_r = finish(next_r, CODE_RESET, STEP_AFTER);
				end else if (EVT.cmd_end) begin
					if (r.auto_ack) begin
						next_r.ack_rel = 1'b1;
						next_r = finish(next_r, CODE_DONE, STEP_ACK_NEG);
					end else begin
						next_r = finish(next_r, CODE_DONE, STEP_AFTER);
					end
				end
			end
			default: begin
				// Illegal code falls back to idle
				next_r.st = S_IDLE;
				next_r.atn = 1'b0;
			end
		endcase

		// A bus reset in idle drops a held ATN unless a command starts
		if (EVT.bus_reset && r.st == S_IDLE && !start_req) begin
			next_r.atn = 1'b0;
		end

		next_r.irq = |(next_r.int_st & next_r.int_en);
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			r <= REGS_RESET;
		end else begin
			r <= next_r;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign PRDATA = r.prdata;
	assign PREADY = r.pready;
	assign PSLVERR = r.pslverr;
	assign CMD_START = r.start;
	assign CMD_ABORT = r.abort;
	assign ATN = r.atn;
	assign FINAL_ACK_RELEASE = r.ack_rel;
	assign IRQ = r.irq;

endmodule // smcr_report

`default_nettype wire

// ### src/smcr_pkg.sv
// Constants, types and register map of the select-with-message reporter
package smcr_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int            ADDR_W        = 12;
	localparam int            DATA_W        = 32;
	localparam logic [11:0]   ADDR_CTRL     = 12'h000;
	localparam logic [11:0]   ADDR_REPORT   = 12'h004;
	localparam logic [11:0]   ADDR_INT_STAT = 12'h008;
	localparam logic [11:0]   ADDR_INT_CLR  = 12'h00c;
	localparam logic [11:0]   ADDR_INT_EN   = 12'h010;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int            CTRL_START    = 0;
	localparam int            CTRL_AUTO_RX  = 1;
	localparam int            CTRL_AUTO_ACK = 2;
	localparam int            REP_CODE_LSB  = 0;
	localparam int            REP_STEP_LSB  = 8;
	localparam int            REP_PEND      = 16;
	localparam int            REP_BUSY      = 17;
	localparam int            INT_REPORT    = 0;
	localparam int            INT_OVERFLOW  = 1;
	localparam int            INT_W         = 2;

	// ----------------------------------------------------------------
	// Report codes and steps
	// ----------------------------------------------------------------
	localparam logic [7:0]    CODE_RESET    = 8'h01;
	localparam logic [7:0]    CODE_TIMEOUT  = 8'h2c;
	localparam logic [7:0]    CODE_FREE     = 8'h31;
	localparam logic [7:0]    CODE_PHASE    = 8'h32;
	localparam logic [7:0]    CODE_NOT_MO   = 8'h54;
	localparam logic [7:0]    CODE_RX_MSG   = 8'h55;
	localparam logic [7:0]    CODE_RX_STAT  = 8'h56;
	localparam logic [7:0]    CODE_DONE     = 8'h60;
	localparam logic [7:0]    CODE_RESEL    = 8'h64;
	localparam logic [7:0]    STEP_WAIT     = 8'h00;
	localparam logic [7:0]    STEP_ARB      = 8'h01;
	localparam logic [7:0]    STEP_SEL      = 8'h02;
	localparam logic [7:0]    STEP_MSG      = 8'h03;
	localparam logic [7:0]    STEP_AFTER    = 8'h04;
	localparam logic [7:0]    STEP_ACK_NEG  = 8'h0c;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [9:0] {
		S_IDLE      = 10'h001,
		S_PRE_RESEL = 10'h002,
		S_WAIT_FREE = 10'h004,
		S_ARB       = 10'h008,
		S_RESEL_W   = 10'h010,
		S_RESEL_OP  = 10'h020,
		S_SEL       = 10'h040,
		S_MSG       = 10'h080,
		S_RECV      = 10'h100,
		S_FIN       = 10'h200
	} smcr_state_t;

	typedef struct packed {
		logic [7:0] code;
		logic [7:0] step;
	} smcr_rep_t;

	typedef struct packed {
		logic bus_free;
		logic arb_won;
		logic arb_lost;
		logic reselected;
		logic sel_done;
		logic first_req;
		logic first_req_msgout;
		logic msg_done;
		logic cmd_end;
		logic bus_reset;
		logic reqack_timeout;
		logic phase_change;
		logic in_msg_done;
		logic in_status_done;
		logic resel_op_done;
	} smcr_evt_t;

	typedef struct packed {
		smcr_state_t             st;
		logic                    got_req;
		logic                    auto_rx;
		logic                    auto_ack;
		logic [INT_W-1:0]        int_en;
		logic [INT_W-1:0]        int_st;
		smcr_rep_t               cur;
		logic                    pend_v;
		smcr_rep_t               pend;
		logic                    atn;
		logic                    start;
		logic                    abort;
		logic                    ack_rel;
		logic                    irq;
		logic                    pready;
		logic                    pslverr;
		logic [DATA_W-1:0]       prdata;
	} smcr_regs_t;

endpackage

// ### verification/smcr_report_monitor.sv
// Port-level assertions for the select-with-message reporter
`timescale 1ns/1ps
`default_nettype none
module smcr_report_monitor
	import smcr_pkg::*;
(
	input wire logic                MCLK,
	input wire logic                RESET,
	input wire logic                PSEL,
	input wire logic                PENABLE,
	input wire logic                PWRITE,
	input wire logic [11:0]         PADDR,
	input wire logic [31:0]         PWDATA,
	input wire logic                PREADY,
	input wire smcr_pkg::smcr_evt_t EVT,
	input wire logic                CMD_START,
	input wire logic                CMD_ABORT,
	input wire logic                ATN,
	input wire logic                FINAL_ACK_RELEASE,
	input wire logic                IRQ
);
	logic [2:0] ph;
	logic       arx;
	logic       aack;
	logic       wr;
	logic       mo;
	logic       fin;
	logic       brk;
	logic       ev;
	assign wr  = PSEL && PENABLE && PWRITE && PREADY;
	assign mo  = ph == 3'h4 && $onehot(EVT);
	assign fin = ph == 3'h5 && $onehot(EVT);
	assign ev  = |EVT;
	assign brk = EVT.bus_reset || EVT.reqack_timeout || EVT.bus_free ||
		EVT.phase_change;
	// ----------
	// Command progress
	// ----------
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			ph   <= 3'h0;
			arx  <= 1'b0;
			aack <= 1'b0;
		end else begin
			if (wr && PADDR == ADDR_CTRL) begin
				arx  <= PWDATA[CTRL_AUTO_RX];
				aack <= PWDATA[CTRL_AUTO_ACK];
			end
			if (CMD_START)
				ph <= 3'h1;
			else if (EVT.bus_reset || EVT.arb_lost || EVT.cmd_end)
				ph <= 3'h0;
			else if (mo && !EVT.msg_done)
				ph <= 3'h0;
			else if ((ph == 3'h1 && EVT.bus_free) ||
				(ph == 3'h2 && EVT.arb_won) ||
				(ph == 3'h3 && EVT.sel_done) ||
				(ph == 3'h4 && EVT.msg_done))
				ph <= ph + 3'h1;
		end
	end
	// ----------
	// Checks
	// ----------
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (RESET);
	a_rst_abort: assert property (
		mo && EVT.bus_reset |=> CMD_ABORT)
		else $error("no abort on bus reset");
	a_tmo_abort: assert property (
		mo && EVT.reqack_timeout |=> CMD_ABORT)
		else $error("no abort on timeout");
	a_free_abort: assert property (
		mo && EVT.bus_free |=> CMD_ABORT)
		else $error("no abort on bus free");
	a_phase_abort: assert property (
		mo && EVT.phase_change |=> CMD_ABORT)
		else $error("no abort on phase change");
	a_atn_kept: assert property (
		mo && EVT.first_req && !arx |=> ATN [*3])
		else $error("attention dropped");
	a_atn_drop: assert property (
		mo && EVT.first_req && arx |=> !ATN)
		else $error("attention kept in receive mode");
	a_ack_mode: assert property (
		fin && EVT.cmd_end |=> FINAL_ACK_RELEASE == aack)
		else $error("final ack release wrong");
	a_abort_cause: assert property (
		$rose(CMD_ABORT) |-> $past(brk))
		else $error("abort without cause");
	a_irq_drop: assert property (
		$fell(IRQ) |-> $past(wr) || $past(RESET))
		else $error("interrupt fell unacknowledged");
	a_irq_rise: assert property (
		$rose(IRQ) |-> $past(wr) || $past(ev))
		else $error("interrupt without event");
	cover property (fin && EVT.cmd_end);
	cover property (mo && EVT.first_req);
	cover property ($rose(CMD_ABORT));
	cover property (ph == 3'h4 && EVT.first_req && EVT.first_req_msgout);
endmodule // smcr_report_monitor

bind smcr_report smcr_report_monitor smcr_report_monitor_inst (
	.MCLK, .RESET, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PREADY,
	.EVT, .CMD_START, .CMD_ABORT, .ATN, .FINAL_ACK_RELEASE, .IRQ
);
`default_nettype wire

// ### verification/smcr_tgt.sv
// Sequencer and target side model for the reporter bench
`timescale 1ns/1ps
`default_nettype none
module smcr_tgt
	import smcr_pkg::*;
#(
	parameter smcr_rep_t RES = 16'h8202
)(
	input  wire logic                MCLK,
	input  wire logic                CMD_START,
	output var  smcr_pkg::smcr_evt_t EVT,
	output var  logic                RESEL_ACTIVE,
	output var  smcr_pkg::smcr_rep_t RESEL_RESULT
);
	logic [14:0] walk [5];
	int          starts;
	int          seen;
	int          lag;
	assign RESEL_RESULT = RES;
	initial begin
		EVT          = '0;
		RESEL_ACTIVE = 1'b0;
		starts       = 0;
		seen         = 0;
		lag          = 0;
		walk         = '{15'h4000, 15'h2000, 15'h0400, 15'h0300, 15'h0080};
	end
	always @(posedge MCLK)
		if (CMD_START === 1'b1)
			starts <= starts + 1;
	// ----------
	// Bus events, one cycle each, after an optional lag
	// ----------
	task automatic send(input logic [14:0] v);
		repeat (lag) @(posedge MCLK);
		EVT <= smcr_evt_t'(v);
		@(posedge MCLK);
		EVT <= '0;
		@(posedge MCLK);
	endtask
	task automatic reach(input int n);
		int k;
		k = 0;
		while (starts == seen && k < 50) begin
			@(posedge MCLK);
			k++;
		end
		seen = starts;
		for (int i = 0; i < n; i++)
			send(walk[i]);
	endtask
	task automatic resel(input logic a);
		RESEL_ACTIVE <= a;
		@(posedge MCLK);
	endtask
endmodule // smcr_tgt
`default_nettype wire

// ### verification/smcr_report_tb.sv
// Self-checking bench for the select-with-message reporter
`timescale 1ns/1ps
`default_nettype none
module smcr_report_tb;
	import smcr_pkg::*;
	localparam smcr_rep_t   RES = 16'h8202;
	localparam logic [14:0] E_FREE = 15'h4000;
	localparam logic [14:0] E_LOST = 15'h1000;
	localparam logic [14:0] E_RSEL = 15'h0800;
	localparam logic [14:0] E_FRQ = 15'h0200;
	localparam logic [14:0] E_END = 15'h0040;
	localparam logic [14:0] E_RST = 15'h0020;
	localparam logic [14:0] E_TMO = 15'h0010;
	localparam logic [14:0] E_PHS = 15'h0008;
	localparam logic [14:0] E_IMSG = 15'h0004;
	localparam logic [14:0] E_ISTS = 15'h0002;
	localparam logic [14:0] E_ROP = 15'h0001;
	logic        MCLK, RESET, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, err;
	logic        RESEL_ACTIVE, CMD_START, CMD_ABORT, ATN, FINAL_ACK_RELEASE;
	logic        IRQ;
	logic [11:0] PADDR;
	logic [31:0] PWDATA, PRDATA, rd;
	smcr_evt_t   EVT;
	smcr_rep_t   RESEL_RESULT;
	int          fails, checked, tn;
	smcr_report smcr_report_inst (
		.MCLK, .RESET, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
		.PREADY, .PSLVERR, .EVT, .RESEL_ACTIVE, .RESEL_RESULT, .CMD_START,
		.CMD_ABORT, .ATN, .FINAL_ACK_RELEASE, .IRQ
	);
	smcr_tgt #(.RES(RES)) smcr_tgt_inst (
		.MCLK, .CMD_START, .EVT, .RESEL_ACTIVE, .RESEL_RESULT
	);
	initial begin
		MCLK = 1'b0;
		forever #2.5 MCLK = ~MCLK;
	end
	// ----------
	// Compare and bus tasks
	// ----------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t word %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_pin(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t pin %b expected %b", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		PSEL    <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE  <= w;
		PADDR   <= a;
		PWDATA  <= d;
		@(posedge MCLK);
		PENABLE <= 1'b1;
		do begin
			@(posedge MCLK);
		end while (PREADY !== 1'b1);
		rd = PRDATA;
		err = PSLVERR;
		PSEL    <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge MCLK);
	endtask
	task automatic run(input logic [1:0] ctl, input int n,
		input logic [14:0] e1, input logic [14:0] e2,
		input logic [15:0] rep, input logic [15:0] pr);
		smcr_tgt_inst.lag = tn % 3;
		apb(1'b1, ADDR_CTRL, {29'h0, ctl, 1'b1});
		smcr_tgt_inst.reach(n);
		if (e1 != 15'h0)
			smcr_tgt_inst.send(e1);
		if (e2 != 15'h0)
			smcr_tgt_inst.send(e2);
		if (pr != 16'h0)
			smcr_tgt_inst.send(E_ROP);
		apb(1'b0, ADDR_REPORT, 32'h0);
		chk(rd, {15'h0, pr != 16'h0, rep[7:0], rep[15:8]});
		chk_pin(IRQ, 1'b1);
		apb(1'b1, ADDR_INT_CLR, 32'h1);
		if (pr != 16'h0) begin
			apb(1'b0, ADDR_REPORT, 32'h0);
			chk(rd, {16'h0, pr[7:0], pr[15:8]});
			chk_pin(IRQ, 1'b1);
			apb(1'b1, ADDR_INT_CLR, 32'h1);
		end
		chk_pin(IRQ, 1'b0);
		tn++;
		$display("test %0d ended", tn);
	endtask
	task automatic give_verdict();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge MCLK);
		fails++;
		$display("ERROR %0t watchdog expired", $time);
		give_verdict();
	end
	// ----------
	// Test sequence
	// ----------
	initial begin
		fails = 0;
		checked = 0;
		tn = 0;
		RESET   <= 1'b1;
		PSEL    <= 1'b0;
		PENABLE <= 1'b0;
		PWRITE  <= 1'b0;
		PADDR   <= 12'h000;
		PWDATA  <= 32'h0;
		repeat (8) @(posedge MCLK);
		RESET <= 1'b0;
		apb(1'b0, ADDR_REPORT, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 12'h014, 32'h0);
		chk(rd, 32'h0);
		chk_pin(err, 1'b1);
		apb(1'b1, ADDR_CTRL, 32'h1);
		smcr_tgt_inst.reach(0);
		smcr_tgt_inst.send(E_RST);
		chk_pin(IRQ, 1'b0);
		apb(1'b0, ADDR_INT_STAT, 32'h0);
		chk(rd, 32'h1);
		apb(1'b1, ADDR_INT_CLR, 32'h1);
		apb(1'b1, ADDR_INT_EN, 32'h1);
		apb(1'b0, ADDR_INT_EN, 32'h0);
		chk(rd, 32'h1);
		chk_pin(IRQ, 1'b0);
		run(2'b00, 0, E_RST, 15'h0, 16'h0100, 16'h0);
		run(2'b00, 1, E_RST, 15'h0, 16'h0101, 16'h0);
		run(2'b00, 2, E_RST, 15'h0, 16'h0102, 16'h0);
		run(2'b00, 3, E_RST, 15'h0, 16'h0103, 16'h0);
		run(2'b00, 5, E_RST, 15'h0, 16'h0104, 16'h0);
		run(2'b00, 3, E_TMO, 15'h0, 16'h2c03, 16'h0);
		run(2'b00, 3, E_FREE, 15'h0, 16'h3103, 16'h0);
		run(2'b00, 3, E_PHS, 15'h0, 16'h3203, 16'h0);
		run(2'b00, 3, E_FRQ, 15'h0, 16'h5403, 16'h0);
		chk_pin(ATN, 1'b1);
		run(2'b01, 3, E_FRQ, E_IMSG, 16'h5503, 16'h0);
		chk_pin(ATN, 1'b0);
		run(2'b01, 3, E_FRQ, E_ISTS, 16'h5603, 16'h0);
		run(2'b00, 5, E_END, 15'h0, 16'h6004, 16'h0);
		run(2'b10, 5, E_END, 15'h0, 16'h600c, 16'h0);
		apb(1'b0, ADDR_CTRL, 32'h0);
		chk(rd, 32'h4);
		run(2'b00, 1, E_LOST, E_RSEL, 16'h6400, RES);
		smcr_tgt_inst.resel(1'b1);
		run(2'b00, 0, 15'h0, 15'h0, RES, 16'h6400);
		smcr_tgt_inst.resel(1'b0);
		give_verdict();
	end
endmodule // smcr_report_tb
`default_nettype wire
